// [bench/ebps_slave.sv]
// far-side memory model: answers after a set number of wait states
`timescale 1ns/1ps
`default_nettype none
module ebps_slave (
    input  wire logic        clk_sys_i,
    input  wire logic        oe_n_i,
    input  wire logic        rw_i,
    input  wire logic [22:0] addr_i,
    input  wire logic [3:0]  waits_i,
    input  wire logic        err_i,
    output logic             ack_n_o,
    output logic             fault_n_o,
    output logic [31:0]      data_o
);
    int cnt = 0;

    function automatic logic [31:0] pat(input logic [22:0] a);
        return {a[7:0], 8'h3c, ~a[7:0], 8'hc3};
    endfunction : pat

    initial
    begin
        ack_n_o = 1'b1;
        fault_n_o = 1'b1;
        data_o = 32'h0000_0000;
    end

    always @(negedge clk_sys_i)
    begin
        if (oe_n_i && rw_i)
        begin
            cnt = 0;
            ack_n_o <= 1'b1;
            fault_n_o <= 1'b1;
        end
        else
        begin
            // a fresh count for each half of a split word
            if (!ack_n_o)
                cnt = 0;
            ack_n_o <= (cnt != waits_i);
            fault_n_o <= !(err_i && cnt == waits_i);
            cnt = cnt + 1;
        end
        // released bus toggles so a stale sample cannot match
        data_o <= !oe_n_i ? pat(addr_i) : ~data_o;
    end
endmodule : ebps_slave
`default_nettype wire

// [bench/tb_top.sv]
// self-checking bench for the port sizing bridge
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import ebps_pkg::*;
    logic clk_sys_i = 1'b0, rst_i = 1'b1, size_fn_en_i = 1'b1, stat_fn_en_i = 1'b1;
    logic req_valid_i = 1'b0, cs_match_i = 1'b1, cs_port16_i = 1'b0, cs_we_opt_i = 1'b0;
    logic cs_ack_i = 1'b0, show_cycle_i = 1'b0, err = 1'b0;
    logic [1:0] mode_i = MODE_MASTER, xfer_size_pin_i = 2'h0;
    logic [3:0] cs_sel_i = 4'h1, core_state_i = 4'h0, core_state_pin_i = 4'h0, waits = 4'h0;
    ebps_req_s req_i = '0;
    logic xfer_done_ack_n_i, xfer_fault_ack_n_i, req_ready_o, done_o, fault_o;
    logic data_oe_o, rw_o, oe_n_o, show_capture_strobe_o, ext_irq_7_o, ext_irq_6_o;
    logic [31:0] data_i, rdata_o, data_o;
    logic [22:0] addr_o;
    logic [1:0] xfer_size_out_o;
    logic [2:0] access_type_code_o;
    logic [3:0] cs_n_o, lane_enable_n_o, core_state_out_o, ext_irq_5_2_o;
    logic [23:0] bus_q[$];
    int failures = 0, total_checks = 0;

    ebps_bridge ebps_bridge_i (.*);
    ebps_slave ebps_slave_i (.clk_sys_i(clk_sys_i), .oe_n_i(oe_n_o), .rw_i(rw_o),
        .addr_i(addr_o), .waits_i(waits), .err_i(err), .ack_n_o(xfer_done_ack_n_i),
        .fault_n_o(xfer_fault_ack_n_i), .data_o(data_i));

    always #12.5 clk_sys_i = ~clk_sys_i;

    // log every pin-acknowledged bus cycle outside single-chip mode; sampled after the slave settles
    always @(negedge clk_sys_i)
    begin
        #1;
        if (!xfer_done_ack_n_i && (!oe_n_o || !rw_o) && mode_i != MODE_SINGLE)
            bus_q.push_back({addr_o[1:0], xfer_size_out_o, lane_enable_n_o, data_o[31:16]});
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic report_and_stop();
        if (failures == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : report_and_stop

    // one request; checks the first bus cycle and the cycles until the answer
    task automatic xfer(input logic wr, input logic [1:0] sz, input logic [22:0] ad,
        input logic [3:0] ln, input logic flt, input int n, input int csk);
        int i;
        bus_q.delete();
        @(negedge clk_sys_i);
        req_i = '{wr, sz, ad, 3'h5, 32'h1234_5678};
        req_valid_i = 1'b1;
        @(negedge clk_sys_i);
        req_valid_i = 1'b0;
        if (flt && !err)
            chk({req_ready_o, oe_n_o, rw_o}, 3'h7);
        else
        begin
            chk(addr_o, ad);
            chk({rw_o, oe_n_o, data_oe_o}, {!wr, wr, wr});
            chk(xfer_size_out_o, sz);
            chk(lane_enable_n_o, ln);
            chk({access_type_code_o, cs_n_o}, {3'h5, ~cs_sel_i});
        end
        for (i = 1; i < 60 && done_o !== 1'b1 && fault_o !== 1'b1; i++)
        begin
            cs_ack_i = (i == csk);
            @(negedge clk_sys_i);
        end
        cs_ack_i = 1'b0;
        chk({fault_o, done_o}, {flt, !flt});
        chk(i, n);
    endtask : xfer

    task automatic t_bytes();
        for (int k = 0; k < 8; k++)
        begin
            cs_port16_i = k[2];
            xfer(1'b0, SZ_BYTE, 23'h01_0200 + k[1:0],
                k[2] ? 4'hf ^ (4'h1 << k[0]) : 4'hf ^ (4'h1 << k[1:0]), 1'b0, 2, 0);
            if (!k[2])
                chk(rdata_o, ebps_slave_i.pat(23'h01_0200 + k[1:0]));
        end
    endtask : t_bytes

    task automatic t_halves();
        for (int k = 0; k < 8; k++)
        begin
            cs_port16_i = k[1];
            xfer(k[2], SZ_HALF, {21'h00_0400, k[0], 1'b0},
                (k[0] && !k[1]) ? 4'h3 : 4'hc, 1'b0, 2, 0);
        end
    endtask : t_halves

    task automatic t_words();
        logic [31:0] e;
        cs_sel_i = 4'h4;
        cs_port16_i = 1'b0;
        xfer(1'b0, SZ_WORD, 23'h00_1230, 4'h0, 1'b0, 2, 0);
        chk(rdata_o, ebps_slave_i.pat(23'h00_1230));
        cs_port16_i = 1'b1;
        waits = 4'h1;
        xfer(1'b0, SZ_WORD, 23'h00_1230, 4'hc, 1'b0, 5, 0);
        e = (ebps_slave_i.pat(23'h00_1230) & 32'hffff_0000) | (ebps_slave_i.pat(23'h00_1232) >> 16);
        chk(rdata_o, e);
        chk(bus_q.size(), 2);
        chk({bus_q[0][23:16], bus_q[1][23:16]}, {A10_ZERO, SZ_WORD, 4'hc, A10_HI, SZ_HALF, 4'hc});
        xfer(1'b1, SZ_WORD, 23'h00_1230, 4'hc, 1'b0, 5, 0);
        chk({bus_q[0][15:0], bus_q[1][15:0]}, 32'h1234_5678);
        cs_match_i = 1'b0;
        xfer(1'b0, SZ_WORD, 23'h00_1230, 4'h0, 1'b0, 3, 0);
        cs_match_i = 1'b1;
        cs_port16_i = 1'b0;
        waits = 4'h0;
    endtask : t_words

    task automatic t_faults();
        xfer(1'b0, SZ_HALF, 23'h00_0101, 4'hf, 1'b1, 1, 0);
        xfer(1'b1, SZ_WORD, 23'h00_0102, 4'hf, 1'b1, 1, 0);
        chk(bus_q.size(), 0);
        err = 1'b1;
        waits = 4'h2;
        xfer(1'b0, SZ_WORD, 23'h00_2000, 4'h0, 1'b1, 4, 0);
        waits = 4'h0;
        cs_port16_i = 1'b1;
        // error on the first half must stop the second
        xfer(1'b1, SZ_WORD, 23'h00_2000, 4'hc, 1'b1, 2, 0);
        chk(bus_q.size(), 1);
        err = 1'b0;
        cs_port16_i = 1'b0;
    endtask : t_faults

    task automatic t_wopt();
        cs_we_opt_i = 1'b1;
        xfer(1'b0, SZ_BYTE, 23'h00_0003, 4'hf, 1'b0, 2, 0);
        xfer(1'b1, SZ_BYTE, 23'h00_0003, 4'h7, 1'b0, 2, 0);
        cs_we_opt_i = 1'b0;
    endtask : t_wopt

    task automatic t_single();
        mode_i = MODE_SINGLE;
        err = 1'b1;
        show_cycle_i = 1'b1;
        xfer(1'b0, SZ_WORD, 23'h00_0040, 4'h0, 1'b0, 4, 3);
        chk(show_capture_strobe_o, 1'b0);
        mode_i = MODE_EMUL;
        err = 1'b0;
        repeat (2) @(negedge clk_sys_i);
        chk(show_capture_strobe_o, 1'b1);
        xfer(1'b0, SZ_BYTE, 23'h00_0001, 4'hd, 1'b0, 2, 0);
        mode_i = MODE_MASTER;
        show_cycle_i = 1'b0;
    endtask : t_single

    task automatic t_pins();
        size_fn_en_i = 1'b0;
        stat_fn_en_i = 1'b0;
        xfer_size_pin_i = 2'h2;
        core_state_pin_i = 4'h9;
        core_state_i = 4'h6;
        repeat (2) @(negedge clk_sys_i);
        chk({ext_irq_7_o, ext_irq_6_o, ext_irq_5_2_o, core_state_out_o}, 10'h290);
        size_fn_en_i = 1'b1;
        stat_fn_en_i = 1'b1;
        repeat (2) @(negedge clk_sys_i);
        chk({ext_irq_7_o, ext_irq_6_o, ext_irq_5_2_o, core_state_out_o}, 10'h006);
    endtask : t_pins

    initial
    begin
        repeat (3) @(posedge clk_sys_i);
        @(negedge clk_sys_i);
        rst_i = 1'b0;
        chk({req_ready_o, rw_o, oe_n_o, data_oe_o, cs_n_o, lane_enable_n_o}, 12'he_ff);
        t_bytes();
        t_halves();
        t_words();
        t_faults();
        t_wopt();
        t_single();
        t_pins();
        report_and_stop();
    end

    // whole run is about a hundred cycles; the 8000-cycle limit leaves ample margin
    initial
    begin
        #200000;
        failures++;
        report_and_stop();
    end
endmodule : tb_top
`default_nettype wire

// [hdl/ebps_bridge.sv]
// external bus master that sizes core operands onto 16- and 32-bit ports
`timescale 1ns/1ps
`default_nettype none
module ebps_bridge (
    input  wire logic                clk_sys_i,
    input  wire logic                rst_i,
    input  wire logic [1:0]          mode_i,
    input  wire logic                size_fn_en_i,
    input  wire logic                stat_fn_en_i,
    input  wire logic                req_valid_i,
    input  wire ebps_pkg::ebps_req_s req_i,
    output logic                     req_ready_o,
    output logic                     done_o,
    output logic                     fault_o,
    output logic [31:0]              rdata_o,
    input  wire logic                cs_match_i,
    input  wire logic                cs_port16_i,
    input  wire logic                cs_we_opt_i,
    input  wire logic [3:0]          cs_sel_i,
    input  wire logic                cs_ack_i,
    input  wire logic                show_cycle_i,
    input  wire logic [3:0]          core_state_i,
    input  wire logic                xfer_done_ack_n_i,
    input  wire logic                xfer_fault_ack_n_i,
    input  wire logic [31:0]         data_i,
    output logic [31:0]              data_o,
    output logic                     data_oe_o,
    output logic [22:0]              addr_o,
    output logic                     rw_o,
    output logic [1:0]               xfer_size_out_o,
    input  wire logic [1:0]          xfer_size_pin_i,
    output logic [2:0]               access_type_code_o,
    output logic [3:0]               cs_n_o,
    output logic                     oe_n_o,
    output logic [3:0]               lane_enable_n_o,
    output logic                     show_capture_strobe_o,
    output logic [3:0]               core_state_out_o,
    input  wire logic [3:0]          core_state_pin_i,
    output logic                     ext_irq_7_o,
    output logic                     ext_irq_6_o,
    output logic [3:0]               ext_irq_5_2_o
);
    import ebps_pkg::*;

    // active-high enables, bit 0 is the top byte lane
    function automatic logic [3:0] lanes(input logic [1:0] sz,
                                         input logic [1:0] a,
                                         input logic       p16);
        logic [3:0] en;
        en = 4'h0;
        case (sz)
            SZ_BYTE:
            begin
                if (p16)
                    en[{1'b0, a[0]}] = 1'b1;
                else
                    en[a] = 1'b1;
            end
            SZ_HALF:
                en = (a[1] && !p16) ? 4'hc : 4'h3;
            default:
                en = p16 ? 4'h3 : 4'hf;
        endcase
        return en;
    endfunction : lanes
    function automatic logic aligned(input logic [1:0] sz,
                                     input logic [1:0] a);
        case (sz)
            SZ_BYTE: return 1'b1;
            SZ_HALF: return !a[0];
            SZ_WORD: return a == A10_ZERO;
            default: return 1'b0;
        endcase
    endfunction : aligned

    ebps_state_e state_r;
    ebps_req_s   req_r;
    logic        port16_r;
    logic        we_opt_r;
    logic        split_r;
    logic        first_r;
    logic ext_ok;
    logic ta_hit;
    logic tea_hit;
    logic take;
    logic bad;
    logic term;
    logic more;
    logic p16_new;
    // acknowledge pins are port pins in single-chip mode
    assign ext_ok  = mode_i != MODE_SINGLE;
    assign ta_hit  = (ext_ok && !xfer_done_ack_n_i) || cs_ack_i;
    assign tea_hit = ext_ok && !xfer_fault_ack_n_i;
    assign take    = req_valid_i && req_ready_o;
    assign bad     = !aligned(req_i.size, req_i.addr[1:0]);
    // error termination outranks a normal one
    assign term    = state_r == ST_RUN && (ta_hit || tea_hit);
    assign more    = term && !tea_hit && split_r && first_r;
    assign p16_new = cs_match_i && cs_port16_i;

    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            state_r     <= ST_IDLE;
            req_ready_o <= 1'b1;
        end
        else
        begin
            case (state_r)
                ST_IDLE:
                begin
                    if (take && !bad)
                    begin
                        state_r     <= ST_RUN;
                        req_ready_o <= 1'b0;
                    end
                end
                ST_RUN:
                begin
                    if (term && !more)
                    begin
                        state_r     <= ST_IDLE;
                        req_ready_o <= 1'b1;
                    end
                end
                default:
                begin
                    state_r     <= ST_IDLE;
                    req_ready_o <= 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            req_r    <= '0;
            port16_r <= 1'b0;
            we_opt_r <= 1'b0;
            split_r  <= 1'b0;
            first_r  <= 1'b0;
        end
        else if (take && !bad)
        begin
            req_r    <= req_i;
            port16_r <= p16_new;
            we_opt_r <= cs_match_i && cs_we_opt_i;
            split_r  <= p16_new && req_i.size == SZ_WORD;
            first_r  <= 1'b1;
        end
        else if (more)
            first_r <= 1'b0;
    end

    // address, size, direction, code and selects
    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            addr_o             <= ADDR_RST;
            xfer_size_out_o    <= SZ_WORD;
            rw_o               <= 1'b1;
            access_type_code_o <= TC_RST;
            cs_n_o             <= CS_OFF;
        end
        else if (take && !bad)
        begin
            addr_o             <= req_i.addr;
            xfer_size_out_o    <= req_i.size;
            rw_o               <= !req_i.write;
            access_type_code_o <= req_i.tcode;
            cs_n_o             <= ~cs_sel_i;
        end
        else if (more)
        begin
            addr_o          <= {req_r.addr[22:2], A10_HI};
            xfer_size_out_o <= SZ_HALF;
        end
        else if (term)
        begin
            rw_o   <= 1'b1;
            cs_n_o <= CS_OFF;
        end
    end

    // strobes that frame the cycle
    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            oe_n_o          <= 1'b1;
            lane_enable_n_o <= LANES_OFF;
            data_oe_o       <= 1'b0;
        end
        else if (take && !bad)
        begin
            oe_n_o    <= req_i.write;
            data_oe_o <= req_i.write;
            // write-enable channels leave reads without lane strobes
            if (!req_i.write && cs_match_i && cs_we_opt_i)
                lane_enable_n_o <= LANES_OFF;
            else
                lane_enable_n_o <= ~lanes(req_i.size, req_i.addr[1:0], p16_new);
        end
        else if (more)
        begin
            if (!req_r.write && we_opt_r)
                lane_enable_n_o <= LANES_OFF;
            else
                lane_enable_n_o <= ~lanes(SZ_HALF, A10_HI, 1'b1);
        end
        else if (term)
        begin
            oe_n_o          <= 1'b1;
            lane_enable_n_o <= LANES_OFF;
            data_oe_o       <= 1'b0;
        end
    end

    // write data; lanes the port does not use carry whatever lies there
    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
            data_o <= DATA_RST;
        else if (take && !bad)
        begin
            if (p16_new && req_i.addr[1])
                data_o <= {req_i.wdata[15:0], req_i.wdata[15:0]};
            else
                data_o <= req_i.wdata;
        end
        else if (more)
            data_o <= {req_r.wdata[15:0], req_r.wdata[15:0]};
    end

    // read capture; only the lanes of the port are taken
    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
            rdata_o <= DATA_RST;
        else if (term && !tea_hit && !req_r.write)
        begin
            if (!port16_r)
                rdata_o <= data_i;
            else if (addr_o[1])
                rdata_o[15:0] <= data_i[31:16];
            else
                rdata_o[31:16] <= data_i[31:16];
        end
    end

    // one-cycle answer pulses to the core
    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            done_o  <= 1'b0;
            fault_o <= 1'b0;
        end
        else
        begin
            done_o  <= term && !tea_hit && !more;
            fault_o <= (take && bad) || (term && tea_hit);
        end
    end

    // pin functions that share the size and status pins
    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            show_capture_strobe_o <= 1'b0;
            core_state_out_o      <= 4'h0;
            ext_irq_7_o           <= 1'b0;
            ext_irq_6_o           <= 1'b0;
            ext_irq_5_2_o         <= 4'h0;
        end
        else
        begin
            show_capture_strobe_o <= show_cycle_i && ext_ok;
            core_state_out_o      <= stat_fn_en_i ? core_state_i : 4'h0;
            ext_irq_5_2_o         <= stat_fn_en_i ? 4'h0 : core_state_pin_i;
            ext_irq_7_o           <= !size_fn_en_i && xfer_size_pin_i[1];
            ext_irq_6_o           <= !size_fn_en_i && xfer_size_pin_i[0];
        end
    end

    property p_rw_dir;
        @(posedge clk_sys_i) disable iff (rst_i)
        state_r == ST_RUN |-> rw_o == !req_r.write;
    endproperty
    a_rw_dir: assert property (p_rw_dir) else $error("direction wrong");
    property p_oe_read;
        @(posedge clk_sys_i) disable iff (rst_i)
        !oe_n_o |-> rw_o && state_r == ST_RUN;
    endproperty
    a_oe_read: assert property (p_oe_read) else $error("oe outside read");
    property p_word_addr;
        @(posedge clk_sys_i) disable iff (rst_i)
        state_r == ST_RUN && xfer_size_out_o == SZ_WORD |-> addr_o[1:0] == 2'h0;
    endproperty
    a_word_addr: assert property (p_word_addr) else $error("word addr low bits");
    property p_split_second;
        @(posedge clk_sys_i) disable iff (rst_i)
        more |=> state_r == ST_RUN && addr_o[1:0] == 2'h2 && xfer_size_out_o == SZ_HALF;
    endproperty
    a_split_second: assert property (p_split_second) else $error("split second bad");
    // a 16-bit port fills the half that its address bit one selects
    property p_read_done;
        @(posedge clk_sys_i) disable iff (rst_i)
        term && !tea_hit && !more && !req_r.write |=> done_o && !fault_o
            && (port16_r ? (addr_o[1] ? rdata_o[15:0] : rdata_o[31:16]) == $past(data_i[31:16])
                         : rdata_o == $past(data_i));
    endproperty
    a_read_done: assert property (p_read_done) else $error("read not latched");
    property p_fault;
        @(posedge clk_sys_i) disable iff (rst_i)
        term && tea_hit |=> fault_o && !done_o && state_r == ST_IDLE;
    endproperty
    a_fault: assert property (p_fault) else $error("error ack not reported");
    property p_lane16;
        @(posedge clk_sys_i) disable iff (rst_i)
        state_r == ST_RUN && port16_r |-> lane_enable_n_o[3:2] == 2'h3;
    endproperty
    a_lane16: assert property (p_lane16) else $error("16-bit port low lanes");
    property p_min_cycle;
        @(posedge clk_sys_i) disable iff (rst_i)
        take && !bad |=> state_r == ST_RUN && !done_o;
    endproperty
    a_min_cycle: assert property (p_min_cycle) else $error("cycle shorter than one clock");
    property p_single_ignore;
        @(posedge clk_sys_i) disable iff (rst_i)
        state_r == ST_RUN && mode_i == MODE_SINGLE && !cs_ack_i |=> !done_o && !fault_o;
    endproperty
    a_single_ignore: assert property (p_single_ignore) else $error("pins acked in single-chip");
    property p_misalign;
        @(posedge clk_sys_i) disable iff (rst_i)
        take && bad |=> fault_o && state_r == ST_IDLE;
    endproperty
    a_misalign: assert property (p_misalign) else $error("misaligned not refused");
endmodule : ebps_bridge
`default_nettype wire

// [pkg/ebps_pkg.sv]
// constants, modes, sizes and request carrier for the external bus port sizing bridge
package ebps_pkg;

    // transfer size codes as driven on the size pins, msb first
    localparam logic [1:0] SZ_BYTE = 2'h1;
    localparam logic [1:0] SZ_HALF = 2'h2;
    localparam logic [1:0] SZ_WORD = 2'h0;

    // chip operating modes
    localparam logic [1:0] MODE_SINGLE = 2'h0;
    localparam logic [1:0] MODE_MASTER = 2'h1;
    localparam logic [1:0] MODE_EMUL   = 2'h2;

    // field widths and the lane count
    localparam int ADDR_W = 23;
    localparam int DATA_W = 32;
    localparam int LANE_N = 4;

    // values after reset and the low address bit codes
    localparam logic [22:0] ADDR_RST  = 23'h00_0000;
    localparam logic [3:0]  LANES_OFF = 4'hf;
    localparam logic [3:0]  CS_OFF    = 4'hf;
    localparam logic [31:0] DATA_RST  = 32'h0000_0000;
    localparam logic [2:0]  TC_RST    = 3'h0;
    localparam logic [1:0]  A10_ZERO  = 2'h0;
    localparam logic [1:0]  A10_HI    = 2'h2;

    typedef struct packed {
        logic        write;
        logic [1:0]  size;
        logic [22:0] addr;
        logic [2:0]  tcode;
        logic [31:0] wdata;
    } ebps_req_s;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_RUN
    } ebps_state_e;

endpackage : ebps_pkg
